// [design/caf_pkg.sv]
// Summary of operation
// - Slot A overflow sets status bit 7; sticky until software clears; resets to zero.
// - Slot B overflow sets status bit 6; only software clears it; resets zero.
// - Transmitter passive flag is high while transmit error count exceeds 127.
// - Receiver passive flag is high while receive error count exceeds 127.
// - Receiver warning is high when receive error count is 96 to 127.
// - Jump width equals jump field plus one quanta, one to four.
// - Time quantum is two times prescaler plus one oscillator periods.
// - Bit timing register is writable only in configuration mode.
// - A valid assembled identifier is compared to filters and, outside configuration mode, moved on match.
// - Mask bit zero accepts any bit; mask one needs identifier equal filter.
// - Filters zero and one with mask zero feed slot A; two to five slot B.
// - A filter match loading slot B, or slot A without double buffering, records the matching filter number.
// - Slot B hit code is the binary filter number, 000 to 101.
// - Slot B codes 000 and 001 occur only via double-buffer rollover.
// - With double buffering, slot A hits read 110 or 111, rollovers 000 or 001.
// - Several matches record the lowest numbered filter.
// - Mask and filter writes take effect only in configuration mode.
// - Mask and filter registers read zero outside configuration mode.
package caf_pkg;
	localparam int ID_W = 29;
	localparam int NUM_FILT = 6;
	localparam logic [7:0] OFS_STATUS = 8'h00;
	localparam logic [7:0] OFS_TIMING = 8'h04;
	localparam logic [7:0] OFS_MODE = 8'h08;
	localparam logic [7:0] OFS_SLOT_A_CTRL = 8'h0C;
	localparam logic [7:0] OFS_SLOT_B_CTRL = 8'h10;
	localparam logic [7:0] OFS_SLOT_A_ID = 8'h14;
	localparam logic [7:0] OFS_SLOT_B_ID = 8'h18;
	localparam logic [7:0] OFS_FILT_BASE = 8'h20;
	localparam logic [7:0] OFS_MASK_BASE = 8'h40;
	localparam int BIT_A_OVF = 7;
	localparam int BIT_B_OVF = 6;
	localparam int BIT_BUS_OFF = 5;
	localparam int BIT_TX_PASS = 4;
	localparam int BIT_RX_PASS = 3;
	localparam int BIT_TX_WARN = 2;
	localparam int BIT_RX_WARN = 1;
	localparam int BIT_ANY_WARN = 0;
	localparam int BIT_MODE_CFG = 0;
	localparam int BIT_MODE_DBEN = 1;
	localparam int BIT_SLOT_FULL = 7;
	localparam logic [8:0] LIM_PASSIVE = 9'h07F;
	localparam logic [8:0] LIM_WARN = 9'h05F;
	localparam logic [8:0] LIM_BUS_OFF = 9'h0FF;
	localparam logic [7:0] RST_TIMING = 8'h00;
	localparam logic [1:0] RST_MODE = 2'h1;
	localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
	localparam logic [1:0] HIT_ROLL_PREFIX = 2'h3;

	typedef struct packed {
		logic valid;
		logic [ID_W-1:0] id;
	} caf_frame_type;

	typedef struct packed {
		logic [8:0] tx_count;
		logic [7:0] rx_count;
	} caf_err_type;

	typedef enum logic [1:0] {BUS_IDLE, BUS_WRITE, BUS_RD_WAIT, BUS_RD_DONE} caf_bus_type;
endpackage

// [design/caf_top.sv]
`timescale 1ns/1ps
module caf_top import caf_pkg::*; (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire logic i_hsel,
	input wire logic [31:0] i_haddr,
	input wire logic [1:0] i_htrans,
	input wire logic i_hwrite,
	input wire logic [2:0] i_hsize,
	input wire logic [31:0] i_hwdata,
	input wire logic i_hready,
	output logic [31:0] o_hrdata,
	output logic o_hreadyout,
	output logic o_hresp,
	input wire caf_frame_type i_frame,
	input wire caf_err_type i_err,
	output logic [7:0] o_comm_status,
	output logic [7:0] o_quantum_cycles,
	output logic [2:0] o_jump_width,
	output logic o_config_mode,
	output logic o_slot_a_full,
	output logic o_slot_b_full
);
	logic rst_meta_ff;
	logic rst_n_ff;
	caf_bus_type bus_ff;
	logic [7:0] addr_ff;
	logic [31:0] hrdata_ff;
	logic [7:0] timing_ff;
	logic [1:0] mode_ff;
	logic [ID_W-1:0] filt_ff [NUM_FILT];
	logic [ID_W-1:0] mask_ff [2];
	logic a_full_ff;
	logic b_full_ff;
	logic [ID_W-1:0] a_id_ff;
	logic [ID_W-1:0] b_id_ff;
	logic [2:0] a_hit_ff;
	logic [2:0] b_hit_ff;
	logic a_ovf_ff;
	logic b_ovf_ff;
	logic [7:0] status_ff;
	logic [7:0] nxt_status;
	logic addr_phase;
	logic wr_now;
	logic [NUM_FILT-1:0] match;
	logic hit_lo;
	logic hit_hi;
	logic [2:0] lo_num;
	logic [2:0] hi_num;
	logic load_a;
	logic load_b;
	logic [2:0] load_b_code;
	logic set_a_ovf;
	logic set_b_ovf;
	logic clr_a_ovf;
	logic clr_b_ovf;
	logic clr_a_full;
	logic clr_b_full;
	logic [31:0] rd_mux;

	function automatic logic id_accept(input logic [ID_W-1:0] id, input logic [ID_W-1:0] filt,
		input logic [ID_W-1:0] mask);
		id_accept = (((id ~^ filt) | ~mask) == {ID_W{1'b1}});
	endfunction

	function automatic logic is_filt(input logic [7:0] a, input int n);
		is_filt = (a == (OFS_FILT_BASE + 8'(n * 4)));
	endfunction

	function automatic logic is_mask(input logic [7:0] a, input int n);
		is_mask = (a == (OFS_MASK_BASE + 8'(n * 4)));
	endfunction

	// Reset release synchroniser
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			rst_meta_ff <= 1'b0;
			rst_n_ff <= 1'b0;
		end else begin
			rst_meta_ff <= 1'b1;
			rst_n_ff <= rst_meta_ff;
		end
	end

	// AHB-Lite slave: writes zero-wait, reads one wait state
	assign addr_phase = i_hsel && i_hready && (i_htrans == HTRANS_NONSEQ);
	assign wr_now = (bus_ff == BUS_WRITE);

	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			bus_ff <= BUS_IDLE;
			addr_ff <= 8'h00;
		end else begin
			unique case (bus_ff)
				BUS_RD_WAIT: begin
					bus_ff <= BUS_RD_DONE;
				end
				default: begin
					if (addr_phase) begin
						bus_ff <= i_hwrite ? BUS_WRITE : BUS_RD_WAIT;
						addr_ff <= i_haddr[7:0];
					end else begin
						bus_ff <= BUS_IDLE;
					end
				end
			endcase
		end
	end

	assign o_hreadyout = (bus_ff != BUS_RD_WAIT);
	assign o_hresp = 1'b0;

	always_comb begin
		rd_mux = 32'h0000_0000;
		unique case (addr_ff)
			OFS_STATUS: rd_mux = {24'h000000, status_ff};
			OFS_TIMING: rd_mux = {24'h000000, timing_ff};
			OFS_MODE: rd_mux = {30'h0000_0000, mode_ff};
			OFS_SLOT_A_CTRL: rd_mux = {24'h000000, a_full_ff, 4'h0, a_hit_ff};
			OFS_SLOT_B_CTRL: rd_mux = {24'h000000, b_full_ff, 4'h0, b_hit_ff};
			OFS_SLOT_A_ID: rd_mux = {3'h0, a_id_ff};
			OFS_SLOT_B_ID: rd_mux = {3'h0, b_id_ff};
			default: rd_mux = 32'h0000_0000;
		endcase
		for (int i = 0; i < NUM_FILT; i++) begin
			if (is_filt(addr_ff, i) && mode_ff[BIT_MODE_CFG]) begin
				rd_mux = {3'h0, filt_ff[i]};
			end
		end
		for (int i = 0; i < 2; i++) begin
			if (is_mask(addr_ff, i) && mode_ff[BIT_MODE_CFG]) begin
				rd_mux = {3'h0, mask_ff[i]};
			end
		end
	end

	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			hrdata_ff <= 32'h0000_0000;
		end else if (bus_ff == BUS_RD_WAIT) begin
			hrdata_ff <= rd_mux;
		end
	end

	assign o_hrdata = hrdata_ff;

	// Mode and bit timing
	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			mode_ff <= RST_MODE;
		end else if (wr_now && addr_ff == OFS_MODE) begin
			mode_ff <= i_hwdata[1:0];
		end
	end

	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			timing_ff <= RST_TIMING;
		end else if (wr_now && addr_ff == OFS_TIMING && mode_ff[BIT_MODE_CFG]) begin
			timing_ff <= i_hwdata[7:0];
		end
	end

	assign o_config_mode = mode_ff[BIT_MODE_CFG];
	assign o_jump_width = {1'b0, timing_ff[7:6]} + 3'h1;
	assign o_quantum_cycles = {1'b0, timing_ff[5:0], 1'b0} + 8'h02;

	// Filters and masks
	genvar g;
	generate
		for (g = 0; g < NUM_FILT; g++) begin : g_filt
			always_ff @(posedge i_clk or negedge rst_n_ff) begin
				if (!rst_n_ff) begin
					filt_ff[g] <= '0;
				end else if (wr_now && is_filt(addr_ff, g) && mode_ff[BIT_MODE_CFG]) begin
					filt_ff[g] <= i_hwdata[ID_W-1:0];
				end
			end
			assign match[g] = id_accept(i_frame.id, filt_ff[g], mask_ff[(g < 2) ? 0 : 1]);
		end
		for (g = 0; g < 2; g++) begin : g_mask
			always_ff @(posedge i_clk or negedge rst_n_ff) begin
				if (!rst_n_ff) begin
					mask_ff[g] <= '0;
				end else if (wr_now && is_mask(addr_ff, g) && mode_ff[BIT_MODE_CFG]) begin
					mask_ff[g] <= i_hwdata[ID_W-1:0];
				end
			end
		end
	endgenerate

	// Lowest numbered match wins within each group
	always_comb begin
		lo_num = 3'h0;
		hi_num = 3'h0;
		hit_lo = 1'b0;
		hit_hi = 1'b0;
		for (int i = 1; i >= 0; i--) begin
			if (match[i]) begin
				lo_num = 3'(i);
				hit_lo = 1'b1;
			end
		end
		for (int i = NUM_FILT - 1; i >= 2; i--) begin
			if (match[i]) begin
				hi_num = 3'(i);
				hit_hi = 1'b1;
			end
		end
	end

	// Steering of a valid assembled message
	always_comb begin
		load_a = 1'b0;
		load_b = 1'b0;
		load_b_code = hi_num;
		set_a_ovf = 1'b0;
		set_b_ovf = 1'b0;
		if (i_frame.valid && !mode_ff[BIT_MODE_CFG]) begin
			if (hit_lo) begin
				if (!a_full_ff) begin
					load_a = 1'b1;
				end else if (mode_ff[BIT_MODE_DBEN] && !b_full_ff) begin
					load_b = 1'b1;
					load_b_code = lo_num;
				end else begin
					set_a_ovf = 1'b1;
				end
			end else if (hit_hi) begin
				if (!b_full_ff) begin
					load_b = 1'b1;
				end else begin
					set_b_ovf = 1'b1;
				end
			end
		end
	end

	assign clr_a_full = wr_now && addr_ff == OFS_SLOT_A_CTRL && !i_hwdata[BIT_SLOT_FULL];
	assign clr_b_full = wr_now && addr_ff == OFS_SLOT_B_CTRL && !i_hwdata[BIT_SLOT_FULL];

	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			a_full_ff <= 1'b0;
			a_id_ff <= '0;
			a_hit_ff <= 3'h0;
		end else if (load_a) begin
			a_full_ff <= 1'b1;
			a_id_ff <= i_frame.id;
			a_hit_ff <= mode_ff[BIT_MODE_DBEN] ? {HIT_ROLL_PREFIX, lo_num[0]} : lo_num;
		end else if (clr_a_full) begin
			a_full_ff <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			b_full_ff <= 1'b0;
			b_id_ff <= '0;
			b_hit_ff <= 3'h0;
		end else if (load_b) begin
			b_full_ff <= 1'b1;
			b_id_ff <= i_frame.id;
			b_hit_ff <= load_b_code;
		end else if (clr_b_full) begin
			b_full_ff <= 1'b0;
		end
	end

	assign o_slot_a_full = a_full_ff;
	assign o_slot_b_full = b_full_ff;

	// Overflow flags: writing zero clears, a new overflow wins
	assign clr_a_ovf = wr_now && addr_ff == OFS_STATUS && !i_hwdata[BIT_A_OVF];
	assign clr_b_ovf = wr_now && addr_ff == OFS_STATUS && !i_hwdata[BIT_B_OVF];

	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			a_ovf_ff <= 1'b0;
		end else if (set_a_ovf) begin
			a_ovf_ff <= 1'b1;
		end else if (clr_a_ovf) begin
			a_ovf_ff <= 1'b0;
		end
	end

	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			b_ovf_ff <= 1'b0;
		end else if (set_b_ovf) begin
			b_ovf_ff <= 1'b1;
		end else if (clr_b_ovf) begin
			b_ovf_ff <= 1'b0;
		end
	end

	// Error state flags from the counters
	always_comb begin
		nxt_status = 8'h00;
		nxt_status[BIT_A_OVF] = a_ovf_ff;
		nxt_status[BIT_B_OVF] = b_ovf_ff;
		nxt_status[BIT_BUS_OFF] = i_err.tx_count > LIM_BUS_OFF;
		nxt_status[BIT_TX_PASS] = i_err.tx_count > LIM_PASSIVE;
		nxt_status[BIT_RX_PASS] = {1'b0, i_err.rx_count} > LIM_PASSIVE;
		nxt_status[BIT_TX_WARN] = (i_err.tx_count > LIM_WARN) && !(i_err.tx_count > LIM_PASSIVE);
		nxt_status[BIT_RX_WARN] = ({1'b0, i_err.rx_count} > LIM_WARN)
			&& !({1'b0, i_err.rx_count} > LIM_PASSIVE);
		nxt_status[BIT_ANY_WARN] = nxt_status[BIT_TX_WARN] | nxt_status[BIT_RX_WARN];
	end

	always_ff @(posedge i_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			status_ff <= 8'h00;
		end else begin
			status_ff <= nxt_status;
		end
	end

	assign o_comm_status = status_ff;
endmodule

// [test/caf_asserts.sv]
`timescale 1ns/1ps
module caf_asserts import caf_pkg::*; (
	input wire logic i_clk,
	input wire logic i_resetn,
	input wire caf_frame_type i_frame,
	input wire caf_err_type i_err,
	input wire logic [7:0] o_comm_status,
	input wire logic [7:0] o_quantum_cycles,
	input wire logic [2:0] o_jump_width,
	input wire logic o_config_mode,
	input wire logic o_slot_a_full,
	input wire logic o_hreadyout
);
	logic [3:0] up_ff;
	logic live;
	logic [8:0] tx;
	logic [7:0] rx;
	// Status is only meaningful once the internal reset copy has let go
	always_ff @(posedge i_clk or negedge i_resetn) begin
		if (!i_resetn) begin
			up_ff <= 4'h0;
		end else begin
			up_ff <= {up_ff[2:0], 1'b1};
		end
	end
	assign live = up_ff[3];
	assign tx = i_err.tx_count;
	assign rx = i_err.rx_count;
	default clocking @(posedge i_clk); endclocking
	default disable iff (!i_resetn);
	property p_tx_pass;
		live |-> o_comm_status[BIT_TX_PASS] == ($past(tx) > LIM_PASSIVE);
	endproperty
	a_tx_pass: assert property (p_tx_pass) else $error("tx passive flag off");
	property p_rx_pass;
		live |-> o_comm_status[BIT_RX_PASS] == ($past(rx) > LIM_PASSIVE);
	endproperty
	a_rx_pass: assert property (p_rx_pass) else $error("rx passive flag off");
	property p_rx_warn;
		live |-> o_comm_status[BIT_RX_WARN] == ($past(rx) > LIM_WARN && $past(rx) <= LIM_PASSIVE);
	endproperty
	a_rx_warn: assert property (p_rx_warn) else $error("rx warning flag off");
	property p_tx_warn;
		live |-> o_comm_status[BIT_TX_WARN] == ($past(tx) > LIM_WARN && $past(tx) <= LIM_PASSIVE);
	endproperty
	a_tx_warn: assert property (p_tx_warn) else $error("tx warning flag off");
	property p_any_warn;
		o_comm_status[BIT_ANY_WARN] == (o_comm_status[BIT_RX_WARN] | o_comm_status[BIT_TX_WARN]);
	endproperty
	a_any_warn: assert property (p_any_warn) else $error("combined warning off");
	property p_bus_off;
		live |-> o_comm_status[BIT_BUS_OFF] == ($past(tx) > LIM_BUS_OFF);
	endproperty
	a_bus_off: assert property (p_bus_off) else $error("bus off flag off");
	property p_cfg_lock;
		!o_config_mode && $past(!o_config_mode) |-> $stable(o_quantum_cycles)
			&& $stable(o_jump_width);
	endproperty
	a_cfg_lock: assert property (p_cfg_lock) else $error("timing changed outside config");
	property p_a_ovf;
		$rose(o_comm_status[BIT_A_OVF]) |-> $past(i_frame.valid, 2);
	endproperty
	a_a_ovf: assert property (p_a_ovf) else $error("slot a overflow without message");
	property p_b_ovf;
		$rose(o_comm_status[BIT_B_OVF]) |-> $past(i_frame.valid, 2);
	endproperty
	a_b_ovf: assert property (p_b_ovf) else $error("slot b overflow without message");
	property p_slot_a;
		$rose(o_slot_a_full) |-> $past(i_frame.valid) && !$past(o_config_mode);
	endproperty
	a_slot_a: assert property (p_slot_a) else $error("slot a loaded without message");
	property p_rdy;
		!o_hreadyout |=> o_hreadyout;
	endproperty
	a_rdy: assert property (p_rdy) else $error("wait state longer than one cycle");
	c_slot_a: cover property ($rose(o_slot_a_full));
	c_a_ovf: cover property ($rose(o_comm_status[BIT_A_OVF]));
	c_rd: cover property (!o_hreadyout);
endmodule
bind caf_top caf_asserts chk_u (.i_clk, .i_resetn, .i_frame, .i_err, .o_comm_status,
	.o_quantum_cycles, .o_jump_width, .o_config_mode, .o_slot_a_full, .o_hreadyout);

// [test/caf_node_model.sv]
`timescale 1ns/1ps
module caf_node_model import caf_pkg::*; (
	input wire logic i_clk,
	output caf_frame_type o_frame,
	output caf_err_type o_err
);
	initial begin
		o_frame = '0;
		o_err = '0;
	end
	// One assembled frame per call; id scrambled while idle
	// Idle edge after each frame keeps valid from being reassigned in one step
	task automatic send(input logic [ID_W-1:0] id);
		o_frame <= {1'b1, id};
		@(posedge i_clk);
		o_frame <= {1'b0, ~id};
		@(posedge i_clk);
	endtask
	task automatic set_err(input logic [8:0] tx, input logic [7:0] rx);
		o_err <= {tx, rx};
	endtask
endmodule

// [test/test_can_accept_filter_status.sv]
`timescale 1ns/1ps
module test_can_accept_filter_status import caf_pkg::*;;
	logic i_clk, i_resetn, i_hsel, i_hwrite, o_hreadyout;
	logic o_hresp, o_config_mode, o_slot_a_full, o_slot_b_full;
	logic [1:0] i_htrans;
	logic [2:0] i_hsize, o_jump_width;
	logic [31:0] i_haddr, i_hwdata, o_hrdata;
	logic [7:0] o_comm_status, o_quantum_cycles;
	caf_frame_type i_frame;
	caf_err_type i_err;
	logic [ID_W-1:0] flt [NUM_FILT];
	logic [8:0] cn [7] = '{9'h000, 9'h05F, 9'h060, 9'h07F, 9'h080, 9'h0FF, 9'h100};
	int fails = 0, num_checks = 0, cyc = 0;
	caf_top dut_u (.i_clk, .i_resetn, .i_hsel, .i_haddr, .i_htrans, .i_hwrite, .i_hsize,
		.i_hwdata, .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout, .o_hresp, .i_frame,
		.i_err, .o_comm_status, .o_quantum_cycles, .o_jump_width, .o_config_mode,
		.o_slot_a_full, .o_slot_b_full);
	caf_node_model node_u (.i_clk, .o_frame(i_frame), .o_err(i_err));
	task automatic end_sim();
		$display("checks %0d errors %0d", num_checks, fails);
		if (fails == 0 && num_checks > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask
	task automatic chk(input logic [31:0] g, input logic [31:0] e);
		num_checks++;
		if (g !== e) begin
			fails++;
			$display("wrong value at %0t: got %h expected %h", $time, g, e);
		end
	endtask
	task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] q);
		i_htrans <= HTRANS_NONSEQ;
		i_haddr <= {24'h0, a};
		i_hwrite <= w;
		do @(negedge i_clk); while (!o_hreadyout);
		@(posedge i_clk);
		i_htrans <= 2'h0;
		i_hwdata <= d;
		do @(negedge i_clk); while (!o_hreadyout);
		q = o_hrdata;
		@(posedge i_clk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		bus(1'b1, a, d, q);
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e);
		logic [31:0] q;
		bus(1'b0, a, 32'h0, q);
		chk(q, e);
	endtask
	function automatic logic [5:0] est(input logic [8:0] t, input logic [7:0] r);
		logic tw, rw;
		tw = t > 9'h05F && t <= 9'h07F;
		rw = r > 8'h5F && r <= 8'h7F;
		return {t > 9'h0FF, t > 9'h07F, r > 8'h7F, tw, rw, tw | rw};
	endfunction
	initial begin
		i_clk = 1'b0;
		forever #2.5 i_clk = ~i_clk;
	end
	always @(posedge i_clk) begin
		cyc <= cyc + 1;
		if (cyc > 30000) begin
			fails++;
			end_sim();
		end
	end
	initial begin
		logic [31:0] v;
		logic [8:0] t;
		logic [7:0] r;
		i_resetn = 1'b0;
		i_hsel = 1'b1;
		i_hsize = 3'h2;
		i_htrans = 2'h0;
		i_hwrite = 1'b0;
		i_haddr = 32'h0;
		i_hwdata = 32'h0;
		void'($urandom(86));
		repeat (5) @(posedge i_clk);
		i_resetn <= 1'b1;
		repeat (3) @(posedge i_clk);
		rd(OFS_MODE, 32'h1);
		chk({o_hresp, o_config_mode, o_slot_a_full, o_slot_b_full}, 4'h4);
		rd(OFS_STATUS, 32'h0);
		for (int i = 0; i < 12; i++) begin
			v = (i < 2) ? {24'h0, {8{i[0]}}} : $urandom & 32'hFF;
			wr(OFS_TIMING, v);
			rd(OFS_TIMING, v);
			@(negedge i_clk);
			chk(o_jump_width, v[7:6] + 3'h1);
			chk(o_quantum_cycles, {v[5:0], 1'b0} + 8'h2);
			@(posedge i_clk);
		end
		for (int n = 0; n < NUM_FILT; n++) begin
			flt[n] = (n == 1) ? flt[0] | 29'h1 : 29'($urandom) & 29'h1FFFFFFE;
			wr(OFS_FILT_BASE + 8'(4 * n), {3'h0, flt[n]});
			rd(OFS_FILT_BASE + 8'(4 * n), {3'h0, flt[n]});
		end
		wr(OFS_MASK_BASE, 32'h1FFFFFFE);
		wr(OFS_MASK_BASE + 8'h4, 32'h1FFFFFFF);
		wr(OFS_MODE, 32'h0);
		wr(OFS_FILT_BASE, 32'h0);
		rd(OFS_FILT_BASE, 32'h0);
		wr(OFS_TIMING, ~v);
		rd(OFS_TIMING, v);
		node_u.send(flt[1]);
		rd(OFS_SLOT_A_CTRL, 32'h80);
		rd(OFS_SLOT_A_ID, {3'h0, flt[1]});
		node_u.send(flt[0]);
		rd(OFS_STATUS, 32'h80);
		for (int n = 2; n < NUM_FILT; n++) begin
			node_u.send(flt[n]);
			rd(OFS_SLOT_B_CTRL, 32'h80 | n);
			rd(OFS_SLOT_B_ID, {3'h0, flt[n]});
			wr(OFS_SLOT_B_CTRL, 32'h0);
			@(negedge i_clk);
			chk({o_hresp, o_slot_b_full}, 2'h0);
			@(posedge i_clk);
		end
		node_u.send(flt[4]);
		node_u.send(flt[5]);
		rd(OFS_SLOT_B_CTRL, 32'h84);
		rd(OFS_STATUS, 32'hC0);
		wr(OFS_STATUS, 32'h40);
		rd(OFS_STATUS, 32'h40);
		wr(OFS_STATUS, 32'h0);
		rd(OFS_STATUS, 32'h0);
		wr(OFS_MODE, 32'h1);
		wr(OFS_MASK_BASE, 32'h1FFFFFFF);
		wr(OFS_SLOT_A_CTRL, 32'h0);
		wr(OFS_SLOT_B_CTRL, 32'h0);
		wr(OFS_MODE, 32'h2);
		node_u.send(~flt[3]);
		rd(OFS_SLOT_A_CTRL, 32'h0);
		node_u.send(flt[1]);
		rd(OFS_SLOT_A_CTRL, 32'h87);
		node_u.send(flt[0]);
		rd(OFS_SLOT_B_CTRL, 32'h80);
		for (int i = 0; i < 16; i++) begin
			t = (i < 7) ? cn[i] : 9'($urandom);
			r = (i < 7) ? cn[6 - i][7:0] : 8'($urandom);
			node_u.set_err(t, r);
			repeat (2) @(posedge i_clk);
			@(negedge i_clk);
			chk(o_comm_status, {2'h0, est(t, r)});
			chk({o_hresp, o_config_mode, o_slot_a_full, o_slot_b_full}, 4'h3);
			@(posedge i_clk);
		end
		end_sim();
	end
endmodule
